// >>> aab_alu.sv
// combinational arithmetic, logic and bit unit
`timescale 1ns/1ps
`default_nettype none
`include "aab_defines.svh"
module aab_alu (
    input wire aab_pkg::aab_op_t op_code,
    input wire logic dest_sel,
    input wire logic [7:0] acc,
    input wire logic [7:0] literal,
    input wire logic [7:0] file_val,
    input wire logic [2:0] bit_idx,
    output logic [7:0] result,
    output logic carry,
    output logic half_carry,
    output logic zero,
    output logic acc_we,
    output logic file_we,
    output logic arith_we,
    output logic zero_we,
    output logic skip_take
);
    // one-hot mask for the addressed bit
    function automatic logic [7:0] bit_mask(input logic [2:0] idx);
        bit_mask = 8'h01 << idx;
    endfunction : bit_mask

    // eight-bit add, nine bits out so the carry is kept
    function automatic logic [8:0] add8(input logic [7:0] a, input logic [7:0] b);
        add8 = {1'b0, a} + {1'b0, b};
    endfunction : add8

    logic [8:0] sum;
    logic [4:0] low_sum;
    logic [7:0] operand;
    logic tested;

    assign operand = (op_code == aab_pkg::op_add_literal_to_acc ||
                      op_code == aab_pkg::op_and_literal_with_acc) ? literal : file_val;
    assign sum = add8(acc, operand);
    assign low_sum = {1'b0, acc[`AAB_NIBBLE_MSB:0]} + {1'b0, operand[`AAB_NIBBLE_MSB:0]};
    assign tested = |(file_val & bit_mask(bit_idx));

    // result, write enables and flag values per operation
    always_comb begin
        result = sum[7:0];
        carry = sum[8];
        half_carry = low_sum[4];
        acc_we = 1'b0;
        file_we = 1'b0;
        arith_we = 1'b0;
        zero_we = 1'b0;
        skip_take = 1'b0;
        unique case (op_code)
            aab_pkg::op_add_literal_to_acc: begin
                acc_we = 1'b1;
                arith_we = 1'b1;
                zero_we = 1'b1;
            end
            aab_pkg::op_add_acc_and_file: begin
                acc_we = !dest_sel;
                file_we = dest_sel;
                arith_we = 1'b1;
                zero_we = 1'b1;
            end
            aab_pkg::op_and_literal_with_acc: begin
                result = acc & literal;
                acc_we = 1'b1;
                zero_we = 1'b1;
            end
            aab_pkg::op_and_acc_with_file: begin
                result = acc & file_val;
                acc_we = !dest_sel;
                file_we = dest_sel;
                zero_we = 1'b1;
            end
            aab_pkg::op_clear_file_bit: begin
                result = file_val & ~bit_mask(bit_idx);
                file_we = 1'b1;
            end
            aab_pkg::op_set_file_bit: begin
                result = file_val | bit_mask(bit_idx);
                file_we = 1'b1;
            end
            aab_pkg::op_test_bit_skip_if_one: skip_take = tested;
            aab_pkg::op_test_bit_skip_if_zero: skip_take = !tested;
            default: ; // no-op and illegal codes write nothing
        endcase
        zero = (result == 8'h00);
    end
endmodule : aab_alu
`default_nettype wire

// >>> aab_core.sv
// execution datapath top: instruction port, register port and i/o port
//
// Strobed register access and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "aab_defines.svh"
module aab_core (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic op_valid,
    input wire aab_pkg::aab_op_t op_code,
    input wire logic [7:0] op_literal,
    input wire logic [6:0] op_file_addr,
    input wire logic [2:0] op_bit_idx,
    input wire logic op_dest_sel,
    input wire logic [7:0] bus_addr,
    input wire logic [7:0] bus_wdata,
    input wire logic bus_wr,
    input wire logic bus_rd,
    output logic [7:0] bus_rdata,
    input wire logic [7:0] port_pins,
    output logic [7:0] port_latch,
    output logic [7:0] acc_out,
    output logic [2:0] flags_out,
    output logic op_done,
    output logic op_skipped,
    output logic skip_pending
);
    logic [7:0] acc_r;
    logic [2:0] flags_r;
    logic [7:0] port_r;
    logic [7:0] rdata_r;
    logic done_r;
    logic skipped_r;
    logic skip_r;
    logic [7:0] pin_meta_r;
    logic [7:0] pin_sync_r;
    logic [7:0] mem_op_data;
    logic [7:0] mem_bus_data;
    logic [7:0] file_val;
    logic [7:0] alu_result;
    logic alu_c;
    logic alu_dc;
    logic alu_z;
    logic alu_acc_we;
    logic alu_file_we;
    logic alu_arith_we;
    logic alu_zero_we;
    logic alu_skip;
    logic exec;
    logic ins_acc_we;
    logic ins_file_we;
    logic bus_file_hit;
    logic bus_file_we;
    logic file_we;
    logic [6:0] file_waddr;
    logic [7:0] file_wdata;
    logic [7:0] bus_file_val;
    logic skip_nxt;

    // an instruction executes unless it is the one being skipped
    assign exec = op_valid && !skip_r;
    assign ins_acc_we = exec && alu_acc_we;
    assign ins_file_we = exec && alu_file_we;
    assign bus_file_hit = !bus_addr[`AAB_FILE_SPACE_BIT];
    // instruction write wins over a bus write in the same cycle
    assign bus_file_we = bus_wr && bus_file_hit && !ins_file_we;
    assign file_we = ins_file_we || bus_file_we;
    assign file_waddr = ins_file_we ? op_file_addr : bus_addr[6:0];
    assign file_wdata = ins_file_we ? alu_result : bus_wdata;

    // port register reads the pins so read-modify-write sees real levels
    assign file_val = (op_file_addr == `AAB_PORT_ADDR) ? pin_sync_r : mem_op_data;
    assign bus_file_val = (bus_addr[6:0] == `AAB_PORT_ADDR) ? pin_sync_r : mem_bus_data;

    aab_file #(
        .DEPTH(`AAB_FILE_DEPTH)
    ) u_file (
        .sys_clk(sys_clk),
        .op_addr(op_file_addr),
        .op_data(mem_op_data),
        .bus_addr(bus_addr[6:0]),
        .bus_data(mem_bus_data),
        .we(file_we),
        .wr_addr(file_waddr),
        .wr_data(file_wdata)
    );

    aab_alu u_alu (
        .op_code(op_code),
        .dest_sel(op_dest_sel),
        .acc(acc_r),
        .literal(op_literal),
        .file_val(file_val),
        .bit_idx(op_bit_idx),
        .result(alu_result),
        .carry(alu_c),
        .half_carry(alu_dc),
        .zero(alu_z),
        .acc_we(alu_acc_we),
        .file_we(alu_file_we),
        .arith_we(alu_arith_we),
        .zero_we(alu_zero_we),
        .skip_take(alu_skip)
    );

    // pins come from outside the clock domain: two flops first
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            pin_meta_r <= 8'h00;
            pin_sync_r <= 8'h00;
        end else begin
            pin_meta_r <= port_pins;
            pin_sync_r <= pin_meta_r;
        end
    end

    // accumulator: instruction result, else bus write
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            acc_r <= `AAB_ACC_RESET;
        end else if (ins_acc_we) begin
            acc_r <= alu_result;
        end else if (bus_wr && bus_addr == `AAB_REG_ACC) begin
            acc_r <= bus_wdata;
        end
    end

    // flags: adds touch all three, ands only zero, bit ops none
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            flags_r <= 3'h0;
        end else if (exec && (alu_arith_we || alu_zero_we)) begin
            if (alu_arith_we) begin
                flags_r[`AAB_FLAG_CARRY] <= alu_c;
                flags_r[`AAB_FLAG_HALF] <= alu_dc;
            end
            flags_r[`AAB_FLAG_ZERO] <= alu_z;
        end else if (bus_wr && bus_addr == `AAB_REG_FLAGS) begin
            flags_r <= bus_wdata[`AAB_FLAGS_W-1:0];
        end
    end

    // output latch of the port register, shadowing writes to its address
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            port_r <= `AAB_PORT_RESET;
        end else if (file_we && file_waddr == `AAB_PORT_ADDR) begin
            port_r <= file_wdata;
        end
    end

    // skip state: a taken test turns the next instruction into a no-op
    assign skip_nxt = skip_r ? !op_valid : (exec && alu_skip);

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            skip_r <= 1'b0;
            done_r <= 1'b0;
            skipped_r <= 1'b0;
        end else begin
            skip_r <= skip_nxt;
            done_r <= op_valid;
            skipped_r <= op_valid && skip_r;
        end
    end

    // register read port: data one cycle after the strobe, zero elsewhere
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            rdata_r <= 8'h00;
        end else if (bus_rd) begin
            if (bus_file_hit) begin
                rdata_r <= bus_file_val;
            end else if (bus_addr == `AAB_REG_ACC) begin
                rdata_r <= acc_r;
            end else if (bus_addr == `AAB_REG_FLAGS) begin
                rdata_r <= {5'h00, flags_r};
            end else begin
                rdata_r <= 8'h00;
            end
        end else begin
            rdata_r <= 8'h00;
        end
    end

    assign bus_rdata = rdata_r;
    assign port_latch = port_r;
    assign acc_out = acc_r;
    assign flags_out = flags_r;
    assign op_done = done_r;
    assign op_skipped = skipped_r;
    assign skip_pending = skip_r;

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (sys_rst);

    // reference sums for the checks, built apart from the alu so a wrong adder shows up
    logic [8:0] ref_sum;
    logic [4:0] ref_low;
    logic [8:0] ref_lit;
    logic [4:0] ref_lit_low;
    logic [7:0] ref_mask;
    assign ref_sum = {1'b0, acc_r} + {1'b0, file_val};
    assign ref_low = {1'b0, acc_r[`AAB_NIBBLE_MSB:0]} + {1'b0, file_val[`AAB_NIBBLE_MSB:0]};
    assign ref_lit = {1'b0, acc_r} + {1'b0, op_literal};
    assign ref_lit_low = {1'b0, acc_r[`AAB_NIBBLE_MSB:0]} + {1'b0, op_literal[`AAB_NIBBLE_MSB:0]};
    assign ref_mask = 8'h01 << op_bit_idx;

    // literal add: sum and all three flags
    AST_ADD_LIT: assert property (
        exec && op_code == aab_pkg::op_add_literal_to_acc
        |=> acc_r == 8'($past(acc_r) + $past(op_literal)))
        else $error("add literal result wrong");
    AST_LIT_FLAGS: assert property (
        exec && op_code == aab_pkg::op_add_literal_to_acc
        |=> flags_r == {acc_r == 8'h00, $past(ref_lit_low[4]), $past(ref_lit[8])})
        else $error("add literal flags wrong");

    // file add and the destination select
    AST_ADD_FLAGS: assert property (
        exec && op_code == aab_pkg::op_add_acc_and_file
        |=> flags_r == {$past(ref_sum[7:0]) == 8'h00, $past(ref_low[4]), $past(ref_sum[8])})
        else $error("add flags wrong");
    AST_ADD_DEST: assert property (
        exec && op_code == aab_pkg::op_add_acc_and_file && !op_dest_sel
        |=> acc_r == $past(ref_sum[7:0]))
        else $error("add to accumulator wrong");
    AST_ADD_FILE: assert property (
        exec && op_code == aab_pkg::op_add_acc_and_file && op_dest_sel
        |-> file_we && file_waddr == op_file_addr && file_wdata == ref_sum[7:0])
        else $error("add to file register wrong");
    AST_DEST_FILE: assert property (
        exec && op_dest_sel && (op_code == aab_pkg::op_add_acc_and_file
        || op_code == aab_pkg::op_and_acc_with_file) |=> $stable(acc_r))
        else $error("destination one changed accumulator");

    // logical and: result and zero flag only
    AST_AND_LIT: assert property (
        exec && op_code == aab_pkg::op_and_literal_with_acc
        |=> acc_r == ($past(acc_r) & $past(op_literal))
        && flags_r[`AAB_FLAG_CARRY] == $past(flags_r[`AAB_FLAG_CARRY]))
        else $error("and literal wrong");
    AST_AND_FLAGS: assert property (
        exec && op_code == aab_pkg::op_and_acc_with_file
        |=> flags_r[1:0] == $past(flags_r[1:0]))
        else $error("and changed carry flags");
    AST_AND_ZERO: assert property (
        exec && op_code == aab_pkg::op_and_acc_with_file
        |=> flags_r[`AAB_FLAG_ZERO] == (($past(acc_r) & $past(file_val)) == 8'h00))
        else $error("and zero flag wrong");

    // bit clear and bit set touch one bit of one register
    AST_CLR_BIT: assert property (
        exec && op_code == aab_pkg::op_clear_file_bit
        |-> file_we && file_waddr == op_file_addr && file_wdata == (file_val & ~ref_mask))
        else $error("bit clear wrong");
    AST_CLR_KEEP: assert property (
        exec && op_code == aab_pkg::op_clear_file_bit
        |=> $stable(flags_r) && $stable(acc_r))
        else $error("bit clear changed flags");
    AST_SET_BIT: assert property (
        exec && op_code == aab_pkg::op_set_file_bit
        |=> $stable(flags_r) && $past(file_wdata[op_bit_idx]) == 1'b1)
        else $error("bit set wrong");
    AST_SET_DATA: assert property (
        exec && op_code == aab_pkg::op_set_file_bit
        |-> file_we && file_waddr == op_file_addr && file_wdata == (file_val | ref_mask))
        else $error("bit set touched other bits");

    // bit tests: a taken skip discards exactly the next valid instruction
    AST_SKIP_ONE: assert property (
        exec && op_code == aab_pkg::op_test_bit_skip_if_one && file_val[op_bit_idx]
        |=> skip_r)
        else $error("skip if one did not skip");
    AST_STAY_ONE: assert property (
        exec && op_code == aab_pkg::op_test_bit_skip_if_one && !file_val[op_bit_idx]
        |=> !skip_r)
        else $error("skip if one skipped on zero");
    AST_SKIP_ZERO: assert property (
        exec && op_code == aab_pkg::op_test_bit_skip_if_zero
        |=> skip_r == !$past(file_val[op_bit_idx]))
        else $error("skip if zero wrong");
    AST_SKIP_HOLD: assert property (
        skip_r && !op_valid
        |=> skip_r)
        else $error("pending skip lost");
    AST_SKIP_NOP: assert property (
        op_valid && skip_r
        |-> !ins_file_we && !ins_acc_we)
        else $error("skipped op wrote state");
    AST_SKIP_DONE: assert property (
        op_valid && skip_r
        |=> op_skipped && !skip_r && $stable(flags_r))
        else $error("skipped op not retired as no-op");
    AST_TEST_KEEP: assert property (
        exec && (op_code == aab_pkg::op_test_bit_skip_if_one
        || op_code == aab_pkg::op_test_bit_skip_if_zero) |-> !ins_file_we ##1 $stable(flags_r)
        && $stable(acc_r))
        else $error("bit test changed state");

    // port read-modify-write and the zero flag
    AST_PORT_PINS: assert property (
        ins_file_we && op_code == aab_pkg::op_set_file_bit && op_file_addr == `AAB_PORT_ADDR
        |=> port_r == ($past(pin_sync_r) | $past(ref_mask)))
        else $error("port read not from pins");
    AST_ZERO_EXACT: assert property (
        exec && alu_zero_we
        |=> flags_r[`AAB_FLAG_ZERO] == ($past(alu_result) == 8'h00))
        else $error("zero flag not exact");

    // main scenarios worth seeing at least once
    COV_ADD_FILE: cover property (exec && op_code == aab_pkg::op_add_acc_and_file && alu_c);
    COV_SKIP: cover property (op_valid && skip_r);
    COV_SKIP_ZERO: cover property (exec && op_code == aab_pkg::op_test_bit_skip_if_zero && alu_skip);
    COV_PORT_RMW: cover property (ins_file_we && op_file_addr == `AAB_PORT_ADDR);
    COV_BUS_RD: cover property (bus_rd ##1 bus_rdata != 8'h00);
endmodule : aab_core
`default_nettype wire

// >>> aab_defines.svh
// constants of the accumulator alu and bit-operation datapath
`ifndef AAB_DEFINES_SVH
`define AAB_DEFINES_SVH
`define AAB_DATA_W 8
`define AAB_FADDR_W 7
`define AAB_BUS_AW 8
`define AAB_FILE_DEPTH 128
`define AAB_REG_ACC 8'h80
`define AAB_REG_FLAGS 8'h81
`define AAB_PORT_ADDR 7'h05
`define AAB_FLAG_CARRY 0
`define AAB_FLAG_HALF 1
`define AAB_FLAG_ZERO 2
`define AAB_FLAGS_W 3
`define AAB_ACC_RESET 8'h00
`define AAB_PORT_RESET 8'h00
`define AAB_NIBBLE_MSB 3
`define AAB_FILE_SPACE_BIT 7
`endif

// >>> aab_file.sv
// file register array with two read ports and one write port
`timescale 1ns/1ps
`default_nettype none
`include "aab_defines.svh"
module aab_file #(
    parameter int DEPTH = `AAB_FILE_DEPTH
) (
    input wire logic sys_clk,
    input wire logic [6:0] op_addr,
    output logic [7:0] op_data,
    input wire logic [6:0] bus_addr,
    output logic [7:0] bus_data,
    input wire logic we,
    input wire logic [6:0] wr_addr,
    input wire logic [7:0] wr_data
);
    // plain storage, no reset: software initialises what it uses
    logic [7:0] mem [DEPTH];

    assign op_data = mem[op_addr];
    assign bus_data = mem[bus_addr];

    // single write port, arbitration is done by the caller
    always_ff @(posedge sys_clk) begin
        if (we) begin
            mem[wr_addr] <= wr_data;
        end
    end
endmodule : aab_file
`default_nettype wire

// >>> aab_pkg.sv
// types shared by the datapath modules
package aab_pkg;
    typedef enum logic [3:0] {
        op_nop,
        op_add_literal_to_acc,
        op_add_acc_and_file,
        op_and_literal_with_acc,
        op_and_acc_with_file,
        op_clear_file_bit,
        op_set_file_bit,
        op_test_bit_skip_if_one,
        op_test_bit_skip_if_zero
    } aab_op_t;
endpackage : aab_pkg

// >>> tb_top.sv
// self-checking testbench for the accumulator alu and bit-operation datapath
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic sys_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic op_valid = 1'b0;
    aab_pkg::aab_op_t op_code = aab_pkg::op_nop;
    logic [7:0] op_literal = 8'h00;
    logic [6:0] op_file_addr = 7'h00;
    logic [2:0] op_bit_idx = 3'h0;
    logic op_dest_sel = 1'b0;
    logic [7:0] bus_addr = 8'h00;
    logic [7:0] bus_wdata = 8'h00;
    logic bus_wr = 1'b0;
    logic bus_rd = 1'b0;
    logic [7:0] port_pins = 8'h3C;
    wire logic [7:0] bus_rdata;
    wire logic [7:0] port_latch;
    wire logic [7:0] acc_out;
    wire logic [2:0] flags_out;
    wire logic op_done;
    wire logic op_skipped;
    wire logic skip_pending;
    // reference state of the model, updated when a request is driven
    logic [7:0] mem [128];
    logic [7:0] acc = 8'h00;
    logic [2:0] flg = 3'h0;
    logic [7:0] latch = 8'h00;
    logic skp = 1'b0;
    logic rd_pend = 1'b0;
    logic [7:0] acc_p = 8'h00;
    logic [2:0] flg_p = 3'h0;
    logic skp_p = 1'b0;
    logic [7:0] latch_p = 8'h00;
    logic [7:0] rq [$];
    logic sq [$];
    int err_count = 0;
    int total_checks = 0;
    logic [6:0] a;
    logic [7:0] va [4] = '{8'hFF, 8'h0F, 8'h00, 8'h88};
    logic [7:0] vb [4] = '{8'h01, 8'h01, 8'h00, 8'h88};

    aab_core u_dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .op_valid(op_valid),
        .op_code(op_code), .op_literal(op_literal), .op_file_addr(op_file_addr),
        .op_bit_idx(op_bit_idx), .op_dest_sel(op_dest_sel), .bus_addr(bus_addr),
        .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata),
        .port_pins(port_pins), .port_latch(port_latch), .acc_out(acc_out),
        .flags_out(flags_out), .op_done(op_done), .op_skipped(op_skipped),
        .skip_pending(skip_pending));

    // 20 MHz clock
    initial begin
        forever #25 sys_clk = ~sys_clk;
    end

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("ERROR %0t: got %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic complete_run;
        if (err_count == 0 && total_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : complete_run

    // the port register reads the pin levels, everything else the array
    function automatic logic [7:0] fval(input logic [6:0] ad);
        return (ad == 7'h05) ? port_pins : mem[ad];
    endfunction : fval

    function automatic void wset(input logic [6:0] ad, input logic [7:0] v);
        mem[ad] = v;
        if (ad == 7'h05) latch = v;
    endfunction : wset

    task automatic idle;
        @(posedge sys_clk);
        op_valid <= 1'b0;
        bus_wr <= 1'b0;
        bus_rd <= 1'b0;
    endtask : idle

    task automatic wr(input logic [7:0] ad, input logic [7:0] d);
        @(posedge sys_clk);
        op_valid <= 1'b0;
        bus_rd <= 1'b0;
        bus_wr <= 1'b1;
        bus_addr <= ad;
        bus_wdata <= d;
        if (ad < 8'h80) wset(ad[6:0], d);
        else if (ad == 8'h80) acc = d;
        else if (ad == 8'h81) flg = d[2:0];
    endtask : wr

    task automatic rd(input logic [7:0] ad);
        @(posedge sys_clk);
        op_valid <= 1'b0;
        bus_wr <= 1'b0;
        bus_rd <= 1'b1;
        bus_addr <= ad;
        if (ad < 8'h80) rq.push_back(fval(ad[6:0]));
        else if (ad == 8'h80) rq.push_back(acc);
        else if (ad == 8'h81) rq.push_back({5'h00, flg});
        else rq.push_back(8'h00);
    endtask : rd

    task automatic op(input aab_pkg::aab_op_t c, input logic [7:0] k, input logic [6:0] ad,
                      input logic [2:0] b, input logic d);
        logic [7:0] f;
        logic [7:0] x;
        logic [7:0] r;
        logic [8:0] s;
        logic lit;
        @(posedge sys_clk);
        bus_wr <= 1'b0;
        bus_rd <= 1'b0;
        op_valid <= 1'b1;
        op_code <= c;
        op_literal <= k;
        op_file_addr <= ad;
        op_bit_idx <= b;
        op_dest_sel <= d;
        f = fval(ad);
        lit = (c == aab_pkg::op_add_literal_to_acc) || (c == aab_pkg::op_and_literal_with_acc);
        x = lit ? k : f;
        sq.push_back(skp);
        if (skp) skp = 1'b0;
        else begin
            case (c)
                aab_pkg::op_add_literal_to_acc, aab_pkg::op_add_acc_and_file: begin
                    s = {1'b0, acc} + {1'b0, x};
                    r = s[7:0];
                    flg = {r == 8'h00, ({1'b0, acc[3:0]} + {1'b0, x[3:0]}) > 5'h0F, s[8]};
                    if (lit || !d) acc = r;
                    else wset(ad, r);
                end
                aab_pkg::op_and_literal_with_acc, aab_pkg::op_and_acc_with_file: begin
                    r = acc & x;
                    flg[2] = (r == 8'h00);
                    if (lit || !d) acc = r;
                    else wset(ad, r);
                end
                aab_pkg::op_clear_file_bit: wset(ad, f & ~(8'h01 << b));
                aab_pkg::op_set_file_bit: wset(ad, f | (8'h01 << b));
                aab_pkg::op_test_bit_skip_if_one: skp = f[b];
                aab_pkg::op_test_bit_skip_if_zero: skp = !f[b];
                default: ;
            endcase
        end
    endtask : op

    // results are taken mid-cycle, where registered outputs have settled
    always @(negedge sys_clk) begin
        if (rd_pend) chk(bus_rdata, rq.pop_front());
        if (op_done) chk({7'h00, op_skipped}, {7'h00, sq.pop_front()});
        // registered outputs trail the model by one edge, so compare with last cycle's model
        chk(acc_out, acc_p);
        chk({5'h00, flags_out}, {5'h00, flg_p});
        chk({7'h00, skip_pending}, {7'h00, skp_p});
        chk(port_latch, latch_p);
        rd_pend = bus_rd;
        acc_p = acc;
        flg_p = flg;
        skp_p = skp;
        latch_p = latch;
    end

    // watchdog sized well above the expected run of at most about 1400 cycles
    initial begin
        repeat (20000) @(posedge sys_clk);
        err_count++;
        complete_run();
    end

    initial begin
        void'($urandom(51));
        repeat (6) @(posedge sys_clk);
        sys_rst <= 1'b0;
        @(negedge sys_clk);
        chk(acc_out, 8'h00);
        chk({5'h00, flags_out}, 8'h00);
        chk(port_latch, 8'h00);
        chk(bus_rdata, 8'h00);
        for (int i = 0; i < 128; i++) wr(8'(i), 8'($urandom));
        wr(8'hC3, 8'h55);
        rd(8'hC3);
        rd(8'h05);
        // adds at the wrap and nibble boundaries, then an and that keeps carry flags
        for (int i = 0; i < 4; i++) begin
            wr(8'h80, va[i]);
            op(aab_pkg::op_add_literal_to_acc, vb[i], 7'h00, 3'h0, 1'b0);
            rd(8'h80);
            rd(8'h81);
        end
        wr(8'h81, 8'h03);
        wr(8'h80, 8'hF0);
        op(aab_pkg::op_and_literal_with_acc, 8'h0F, 7'h00, 3'h0, 1'b0);
        rd(8'h81);
        // read-modify-write of the port register takes the pins, not the latch
        wr(8'h05, 8'h00);
        port_pins <= 8'hA5;
        repeat (3) idle();
        op(aab_pkg::op_set_file_bit, 8'h00, 7'h05, 3'h1, 1'b0);
        idle();
        @(negedge sys_clk);
        chk(port_latch, 8'hA7);
        for (int i = 0; i < 400; i++) begin
            a = 7'($urandom_range(0, 127));
            op(aab_pkg::aab_op_t'($urandom_range(0, 8)), 8'($urandom), a, 3'($urandom),
               1'($urandom));
            case ($urandom_range(0, 3))
                0: idle();
                1: rd({1'b0, a});
                2: begin
                    rd(8'h80);
                    rd(8'h81);
                end
                default: ;
            endcase
        end
        idle();
        repeat (2) @(posedge sys_clk);
        @(negedge sys_clk);
        chk(port_latch, latch);
        complete_run();
    end
endmodule : tb_top
`default_nettype wire
